/* File: sim/dac_comparator_control_properties.sv */
/* checker for dac_comparator_control: bus handshake, pin overrides and routes.
   sees only the top ports; assumes ce stays high. */
`timescale 1ns/100ps
module dac_comparator_control_properties
  import dac_cmp_pkg::*;
(
  // clock, reset, bus
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  // pins and controls
  input wire logic cmp_pin_direction_bit,
  input wire logic ref_pin_in,
  input wire logic ref_conv_on,
  input wire logic [2:0] ref_pos_source_sel,
  input wire logic ref_neg_source_gnd,
  input wire logic ref_pin_drive_en,
  input wire logic ref_pin_digital_override,
  input wire logic ref_pin_read,
  input wire logic cmp_on,
  input wire route_t cmp_pos_route,
  input wire logic cmp_result_raw,
  input wire logic cmp_pin_oe,
  input wire logic cmp_port_override,
  input wire logic cmp_irq_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_bus_ack_once: assert property (s_req |=> s_ack_pulse)
    else $error("bus ack not a single pulse");
  a_pin_drive_cond: assert property (
    cmp_pin_oe |-> cmp_on && !$past(cmp_pin_direction_bit)) else $error("comparator pin driven wrongly");
  a_port_override: assert property (cmp_pin_oe |-> cmp_port_override)
    else $error("pin driven without port override");
  a_ref_pin_link: assert property (
    ref_pin_drive_en |-> ref_conv_on && ref_pin_digital_override) else $error("reference pin link wrong");
  a_ref_read_zero: assert property (
    ref_pin_drive_en && $past(ref_pin_drive_en) |-> !ref_pin_read) else $error("reference pin read not zero");
  // first edge after reset still holds the reset value of the read flop
  a_ref_read_pass: assert property (
    !$past(reset) && !ref_pin_drive_en && !$past(ref_pin_drive_en) |-> ref_pin_read == $past(ref_pin_in))
    else $error("reference pin read not passed");
  a_ref_source_on: assert property (
    !$past(reset) |-> $onehot0(ref_pos_source_sel) && (ref_pos_source_sel == 3'h0 || ref_conv_on)
    && ref_neg_source_gnd == ref_conv_on) else $error("converter source select wrong");
  a_cmp_route_on: assert property (
    cmp_pos_route != 4'h0 |-> cmp_on && $onehot(cmp_pos_route)) else $error("positive route wrong");
  a_cmp_off_low: assert property (!cmp_on [*3] |-> !cmp_result_raw)
    else $error("result high while off");
  a_flag_sticky: assert property (
    cmp_irq_flag && !(wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) |=> cmp_irq_flag)
    else $error("flag dropped without write");
endmodule
bind dac_comparator_control dac_comparator_control_properties u_props (.*);

/* File: sim/dac_comparator_control_tb_top.sv */
/* testbench for dac_comparator_control: wishbone master, pin drivers, read scoreboard.
   assumes the design and checker compiled before it; ce held high, timer clock driven by hand. */
`timescale 1ns/100ps
module dac_comparator_control_tb_top;
  logic clk = 1'h0, reset = 1'h1, ce = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic instr_cycle_stb = 1'h0, tmr1_src_clk = 1'h0, cmp_decision = 1'h0;
  logic cmp_pin_direction_bit = 1'h0, ref_pin_in = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rexp;
  logic wb_ack_o, ref_conv_on, ref_neg_source_gnd, ref_pin_drive_en, ref_pin_digital_override, ref_pin_read;
  logic cmp_on, cmp_speed_power_sel, cmp_hyst_en, cmp_result_synced, cmp_result_raw, cmp_pin_out;
  logic cmp_pin_oe, cmp_port_override, cmp_irq_flag;
  logic [4:0] ref_level_code;
  logic [2:0] ref_pos_source_sel;
  logic [3:0] cmp_pos_route, cmp_neg_route;
  logic [1:0] tick = 2'h0;
  logic [31:0] exp_q[$];
  int num_errors = 0, comparisons = 0, cycles = 0;

  dac_comparator_control DUT (.*);

  always #2.5 clk = ~clk;

  always @(posedge clk)
  begin
    tick <= tick + 2'h1;
    instr_cycle_stb <= (tick == 2'h3);
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      end_sim();
    end
  end

  // read data is judged at the ack edge, the first edge it is valid
  always @(posedge clk)
  begin
    if (wb_ack_o === 1'h1 && wb_we_i === 1'h0)
    begin
      rexp = exp_q.size() ? exp_q.pop_front() : 32'hx;
      chk(wb_dat_o, rexp);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    // no wait limit here, the bench timeout ends a hung access
    do
    begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'h1);
    chk(n, 32'h2);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'h0, a, 8'h00);
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic end_sim();
    $display("num_errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    logic [7:0] d;
    int k;
    static logic [3:0] nexp [8] = '{4'h1, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h8};
    static logic [7:0] ma [3] = '{8'h00, 8'h04, 8'h0c};
    static logic [7:0] mm [3] = '{8'hac, 8'h1f, 8'hf7};
    d = 8'($urandom(32'h4548));
    repeat (3) @(posedge clk);
    reset <= 1'h0;
    chk({31'h0, cmp_speed_power_sel}, 32'h1);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h4);
    for (k = 0; k < 3; k++)
    begin
      d = 8'($urandom);
      wb(1'h1, ma[k], d);
      rd(ma[k], {24'h0, d & mm[k]});
    end
    wb(1'h1, 8'h18, 8'hff);
    rd(8'h18, 32'h0);
    wb(1'h1, 8'h04, 8'h15);
    wb_sel_i <= 4'h0;
    wb(1'h1, 8'h04, 8'h0a);
    wb_sel_i <= 4'h1;
    rd(8'h04, 32'h15);
    for (k = 0; k < 4; k++)
    begin
      wb(1'h1, 8'h00, 8'ha0 | 8'(k << 2));
      w(2);
      chk({ref_pos_source_sel, ref_neg_source_gnd, ref_conv_on, ref_pin_drive_en, ref_pin_digital_override, ref_pin_read,
        ref_level_code}, {(k == 3) ? 3'h0 : 3'(1 << k), 5'h1e, 5'h15});
    end
    ref_pin_in <= 1'($urandom);
    wb(1'h1, 8'h00, 8'h80);
    w(2);
    chk({ref_pin_drive_en, ref_pin_read}, {1'h0, ref_pin_in});
    wb(1'h1, 8'h08, 8'ha4);
    for (k = 0; k < 8; k++)
    begin
      wb(1'h1, 8'h0c, 8'h80 | 8'((k & 3) << 4) | 8'(k & 7));
      w(2);
      chk({cmp_pos_route, cmp_neg_route}, {4'h1 << k[1:0], nexp[k]});
    end
    cmp_decision <= 1'h1;
    w(12);
    chk({cmp_result_synced, cmp_result_raw, cmp_pin_out, cmp_pin_oe, cmp_irq_flag}, 5'h1f);
    rd(8'h08, 32'he4);
    rd(8'h10, 32'h1);
    wb(1'h1, 8'h08, 8'hb4);
    w(12);
    rd(8'h08, 32'hb4);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h1);
    wb(1'h1, 8'h14, 8'h01);
    rd(8'h14, 32'h0);
    cmp_pin_direction_bit <= 1'h1;
    w(2);
    chk({cmp_pin_oe, cmp_port_override}, 2'h1);
    wb(1'h1, 8'h08, 8'h20);
    w(2);
    chk({cmp_on, cmp_port_override, cmp_speed_power_sel, cmp_pos_route}, 7'h20);
    // timer-synchronised mode: result follows only a falling timer clock edge
    cmp_pin_direction_bit <= 1'h0;
    wb(1'h1, 8'h0c, 8'h77);
    wb(1'h1, 8'h08, 8'ha3);
    w(12);
    chk({cmp_hyst_en, cmp_result_synced, cmp_pin_out, cmp_result_raw, cmp_pin_oe}, 5'h13);
    tmr1_src_clk <= 1'h1;
    w(2);
    chk({cmp_result_synced, cmp_pin_out}, 2'h0);
    tmr1_src_clk <= 1'h0;
    w(3);
    chk({cmp_result_synced, cmp_pin_out}, 2'h3);
    cmp_decision <= 1'h0;
    w(12);
    chk({cmp_irq_flag, cmp_result_synced, cmp_result_raw}, 3'h6);
    rd(8'h14, 32'h1);
    reset <= 1'h1;
    w(2);
    reset <= 1'h0;
    w(2);
    chk({ref_conv_on, ref_pin_drive_en, ref_level_code, cmp_speed_power_sel, cmp_hyst_en, cmp_irq_flag}, 10'h004);
    end_sim();
  end
endmodule

/* File: src/dac_cmp_pkg.sv */
/*
  Types shared by the reference converter and comparator control block.
  Assumes nothing of its surroundings.
*/
package dac_cmp_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [4:0] level_code_t;
  typedef logic [1:0] pos_sel_t;
  typedef logic [2:0] neg_sel_t;
  // one-hot analog switch controls
  typedef logic [3:0] route_t;
endpackage

/* File: src/dac_cmp_regs.svh */
/*
  Register offsets, field positions, write masks and reset values of the
  reference converter and comparator control block.
  Assumes byte addresses on a 32-bit classic Wishbone bus, one register per word.
*/
`ifndef DAC_CMP_REGS_SVH
`define DAC_CMP_REGS_SVH

// byte offsets
`define REF_CTRL0_OFS 5'h00
`define REF_LEVEL_OFS 5'h04
`define CMP_CTRL0_OFS 5'h08
`define CMP_CTRL1_OFS 5'h0c
`define CMP_RESULT_OFS 5'h10
`define CMP_FLAG_OFS 5'h14

// reference control 0 fields
`define REF_ON_BIT 7
`define REF_PIN_BIT 5
`define REF_SRC_HI 3
`define REF_SRC_LO 2
`define REF_CTRL0_MASK 8'hac
`define REF_CTRL0_RST 8'h00

// level select
`define REF_LEVEL_MASK 8'h1f
`define REF_LEVEL_RST 8'h00

// comparator control 0 fields
`define CMP_ON_BIT 7
`define CMP_OUT_BIT 6
`define CMP_OE_BIT 5
`define CMP_POL_BIT 4
`define CMP_SP_BIT 2
`define CMP_HYS_BIT 1
`define CMP_SYNC_BIT 0
`define CMP_CTRL0_MASK 8'hb7
`define CMP_CTRL0_RST 8'h04

// comparator control 1 fields
`define CMP_RISE_BIT 7
`define CMP_FALL_BIT 6
`define CMP_PCH_HI 5
`define CMP_PCH_LO 4
`define CMP_NCH_HI 2
`define CMP_NCH_LO 0
`define CMP_CTRL1_MASK 8'hf7
`define CMP_CTRL1_RST 8'h00

// flag register: bit 0, write one to clear
`define CMP_FLAG_BIT 0

`endif

/* File: src/dac_comparator_control.sv */
/*
  Digital control of a 5-bit reference ladder converter and one comparator:
  register file on classic Wishbone, switch controls, pin overrides, result
  registering, timer synchronisation and the edge flag.
  Assumes the analog comparator decision arrives asynchronously, the timer
  clock input is already past its prescaler, and the instruction-cycle strobe
  is a one-cycle pulse synchronous to clk.
*/
// The implementer's own choices: the Wishbone interface to the registers and the address map.
// Summary of operation
// - converter runs only while its enable bit is set
// - 32 levels from a 5-bit code, span times code over 32
// - pin drive bit connects converter level to its output pin
// - reference pin overrides output buffer, pull-up and input detector
// - port read of reference output pin returns zero
// - wake from sleep leaves reference control 0 untouched
// - reset disables converter, frees pin, clears level code
// - source field picks supply, reference pin or fixed buffer; ground negative
// - unimplemented reference bits read zero, writes ignored
// - comparator on bit enables it; off disables all inputs
// - 2-bit positive channel routes one of four sources
// - 3-bit negative channel routes one source to inverting input
// - result readable in control 0 and mirrored in result register
// - pin driven only with drive enable, direction clear, comparator on
// - synced result to converter and timer, raw result to waveform unit
// - pin drive enable overrides port latch regardless of on bit
// - internal result registered once per instruction cycle
// - result high when positive exceeds negative; invert bit flips it
// - speed/power bit resets to one, zero selects low power
// - raw decision low when positive below negative, high above
// - positive codes: pin, converter, fixed reference, ground
// - negative codes: pin a, pin b, fixed reference, ground; rest reserved
// - sync mode latches result on timer source clock falling edge
// - enabled rising or falling result edge sets flag; software clears
`timescale 1ns/100ps
`include "dac_cmp_regs.svh"

module dac_comparator_control
  import dac_cmp_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock, reset, freeze
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core timing and pins
  input wire logic instr_cycle_stb,
  input wire logic tmr1_src_clk,
  input wire logic cmp_decision,
  input wire logic cmp_pin_direction_bit,
  input wire logic ref_pin_in,
  // converter controls
  output logic ref_conv_on,
  output level_code_t ref_level_code,
  output logic [2:0] ref_pos_source_sel,
  output logic ref_neg_source_gnd,
  output logic ref_pin_drive_en,
  output logic ref_pin_digital_override,
  output logic ref_pin_read,
  // comparator controls
  output logic cmp_on,
  output logic cmp_speed_power_sel,
  output logic cmp_hyst_en,
  output route_t cmp_pos_route,
  output route_t cmp_neg_route,
  // comparator results
  output logic cmp_result_synced,
  output logic cmp_result_raw,
  output logic cmp_pin_out,
  output logic cmp_pin_oe,
  output logic cmp_port_override,
  output logic cmp_irq_flag
);

  // refused at elaboration: the offset decode needs bits 4:2 and a zero test above them
  if (ADDR_W < 6)
  begin : g_addr_check
    $error("ADDR_W must be at least 6");
  end

  reg8_t ref_ctrl0_q;
  reg8_t ref_level_q;
  reg8_t cmp_ctrl0_q;
  reg8_t cmp_ctrl1_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic raw_meta_q;
  logic raw_sync_q;
  logic cmp_result_q;
  logic tmr_clk_prev_q;
  logic tmr_latch_q;
  logic flag_q;
  logic ref_on_q;
  level_code_t level_out_q;
  logic [2:0] src_q;
  logic gnd_q;
  logic ref_oe_q;
  logic ref_ovr_q;
  logic ref_read_q;
  logic cmp_on_q;
  logic sp_q;
  logic hys_q;
  route_t pos_q;
  route_t neg_q;
  logic synced_q;
  logic raw_out_q;
  logic pin_out_q;
  logic pin_oe_q;
  logic port_ovr_q;

  // bus decode
  wire req = wb_cyc_i & wb_stb_i;
  wire take = req & ~ack_q;
  wire upper_zero = ~|wb_adr_i[ADDR_W-1:5];
  wire [4:0] ofs = {wb_adr_i[4:2], 2'b00};
  wire wr = req & ack_q & wb_we_i & wb_sel_i[0] & upper_zero;
  wire wr_ref0 = wr & (ofs == `REF_CTRL0_OFS);
  wire wr_ref1 = wr & (ofs == `REF_LEVEL_OFS);
  wire wr_cmp0 = wr & (ofs == `CMP_CTRL0_OFS);
  wire wr_cmp1 = wr & (ofs == `CMP_CTRL1_OFS);
  wire wr_flag = wr & (ofs == `CMP_FLAG_OFS);
  wire [7:0] wdat = wb_dat_i[7:0];

  // field views
  wire ref_en = ref_ctrl0_q[`REF_ON_BIT];
  wire ref_pin = ref_ctrl0_q[`REF_PIN_BIT];
  wire [1:0] ref_src = ref_ctrl0_q[`REF_SRC_HI:`REF_SRC_LO];
  wire c_on = cmp_ctrl0_q[`CMP_ON_BIT];
  wire c_oe = cmp_ctrl0_q[`CMP_OE_BIT];
  wire c_pol = cmp_ctrl0_q[`CMP_POL_BIT];
  wire c_sync = cmp_ctrl0_q[`CMP_SYNC_BIT];
  wire c_rise = cmp_ctrl1_q[`CMP_RISE_BIT];
  wire c_fall = cmp_ctrl1_q[`CMP_FALL_BIT];
  wire pos_sel_t c_pch = cmp_ctrl1_q[`CMP_PCH_HI:`CMP_PCH_LO];
  wire neg_sel_t c_nch = cmp_ctrl1_q[`CMP_NCH_HI:`CMP_NCH_LO];

  // read mux; result bit merged into control 0
  wire reg8_t cmp0_rd = (cmp_ctrl0_q & ~(8'h01 << `CMP_OUT_BIT)) | ({7'h00, cmp_result_q} << `CMP_OUT_BIT);
  wire reg8_t rd_byte =
    ~upper_zero ? 8'h00 :
    (ofs == `REF_CTRL0_OFS) ? ref_ctrl0_q :
    (ofs == `REF_LEVEL_OFS) ? ref_level_q :
    (ofs == `CMP_CTRL0_OFS) ? cmp0_rd :
    (ofs == `CMP_CTRL1_OFS) ? cmp_ctrl1_q :
    (ofs == `CMP_RESULT_OFS) ? {7'h00, cmp_result_q} :
    (ofs == `CMP_FLAG_OFS) ? {7'h00, flag_q} :
    8'h00;

  // comparator result path; gating by on bit models disabled inputs
  wire res_now = c_on & (raw_sync_q ^ c_pol);
  wire tmr_fall = tmr_clk_prev_q & ~tmr1_src_clk;
  wire rise_evt = instr_cycle_stb & res_now & ~cmp_result_q & c_rise;
  wire fall_evt = instr_cycle_stb & ~res_now & cmp_result_q & c_fall;
  wire flag_clr = wr_flag & wdat[`CMP_FLAG_BIT];
  // set wins so an edge during the clear is kept
  wire flag_d = (flag_q & ~flag_clr) | rise_evt | fall_evt;
  wire synced_d = c_sync ? tmr_latch_q : cmp_result_q;

  // switch decodes
  wire [2:0] src_d = ~ref_en ? 3'h0 :
    (ref_src == 2'h0) ? 3'h1 :
    (ref_src == 2'h1) ? 3'h2 :
    (ref_src == 2'h2) ? 3'h4 : 3'h0;
  wire route_t pos_d = c_on ? (4'h1 << c_pch) : 4'h0;
  wire route_t neg_d = ~c_on ? 4'h0 :
    (c_nch == 3'h0) ? 4'h1 :
    (c_nch == 3'h1) ? 4'h2 :
    (c_nch == 3'h6) ? 4'h4 :
    (c_nch == 3'h7) ? 4'h8 : 4'h0;
  wire ref_oe_d = ref_en & ref_pin;

  // bus handshake
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ack_q <= take;
      if (take)
      begin
        dat_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // software registers; no sleep input, wake leaves them as they were
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ref_ctrl0_q <= `REF_CTRL0_RST;
      ref_level_q <= `REF_LEVEL_RST;
      cmp_ctrl0_q <= `CMP_CTRL0_RST;
      cmp_ctrl1_q <= `CMP_CTRL1_RST;
    end
    else if (ce)
    begin
      if (wr_ref0)
      begin
        ref_ctrl0_q <= wdat & `REF_CTRL0_MASK;
      end
      if (wr_ref1)
      begin
        ref_level_q <= wdat & `REF_LEVEL_MASK;
      end
      if (wr_cmp0)
      begin
        cmp_ctrl0_q <= wdat & `CMP_CTRL0_MASK;
      end
      if (wr_cmp1)
      begin
        cmp_ctrl1_q <= wdat & `CMP_CTRL1_MASK;
      end
    end
  end

  // decision synchroniser, the meta stage feeds only the second stage
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      raw_meta_q <= 1'b0;
      raw_sync_q <= 1'b0;
    end
    else if (ce)
    begin
      raw_meta_q <= cmp_decision;
      raw_sync_q <= raw_meta_q;
    end
  end

  // instruction-cycle result, timer latch and flag
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cmp_result_q <= 1'b0;
      tmr_clk_prev_q <= 1'b0;
      tmr_latch_q <= 1'b0;
      flag_q <= 1'b0;
    end
    else if (ce)
    begin
      if (instr_cycle_stb)
      begin
        cmp_result_q <= res_now;
      end
      tmr_clk_prev_q <= tmr1_src_clk;
      if (tmr_fall)
      begin
        tmr_latch_q <= cmp_result_q;
      end
      flag_q <= flag_d;
    end
  end

  // converter outputs
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ref_on_q <= 1'b0;
      level_out_q <= 5'h00;
      src_q <= 3'h0;
      gnd_q <= 1'b1;
      ref_oe_q <= 1'b0;
      ref_ovr_q <= 1'b0;
      ref_read_q <= 1'b0;
    end
    else if (ce)
    begin
      ref_on_q <= ref_en;
      level_out_q <= ref_level_q[4:0];
      src_q <= src_d;
      gnd_q <= ref_en;
      ref_oe_q <= ref_oe_d;
      ref_ovr_q <= ref_oe_d;
      ref_read_q <= ref_oe_d ? 1'b0 : ref_pin_in;
    end
  end

  // comparator outputs
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cmp_on_q <= 1'b0;
      sp_q <= 1'b1;
      hys_q <= 1'b0;
      pos_q <= 4'h0;
      neg_q <= 4'h0;
      synced_q <= 1'b0;
      raw_out_q <= 1'b0;
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
      port_ovr_q <= 1'b0;
    end
    else if (ce)
    begin
      cmp_on_q <= c_on;
      sp_q <= cmp_ctrl0_q[`CMP_SP_BIT];
      hys_q <= cmp_ctrl0_q[`CMP_HYS_BIT];
      pos_q <= pos_d;
      neg_q <= neg_d;
      synced_q <= synced_d;
      raw_out_q <= res_now;
      pin_out_q <= synced_d;
      pin_oe_q <= c_oe & ~cmp_pin_direction_bit & c_on;
      port_ovr_q <= c_oe;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign ref_conv_on = ref_on_q;
  assign ref_level_code = level_out_q;
  assign ref_pos_source_sel = src_q;
  assign ref_neg_source_gnd = gnd_q;
  assign ref_pin_drive_en = ref_oe_q;
  assign ref_pin_digital_override = ref_ovr_q;
  assign ref_pin_read = ref_read_q;
  assign cmp_on = cmp_on_q;
  assign cmp_speed_power_sel = sp_q;
  assign cmp_hyst_en = hys_q;
  assign cmp_pos_route = pos_q;
  assign cmp_neg_route = neg_q;
  assign cmp_result_synced = synced_q;
  assign cmp_result_raw = raw_out_q;
  assign cmp_pin_out = pin_out_q;
  assign cmp_pin_oe = pin_oe_q;
  assign cmp_port_override = port_ovr_q;
  assign cmp_irq_flag = flag_q;

endmodule
